// >>> hw/rt_message_writer.sv
// Remote terminal message data structure writer with Wishbone register slave
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.

////////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Every receive message gets an information word then a time-tag word.
// [RULE2] Data words go to the selected pointer plus two onward.
// [RULE3] Information and time-tag still written on error; later data is dropped.
// [RULE4] Info bits 15..11 carry the command word count field.
// [RULE5] Info bit 9 is one for channel A, zero for channel B.
// [RULE6] Receive info bit 8 flags a terminal-to-terminal transfer.
// [RULE7] Info bit 7 flags any message error, cause in bits 4..0. A link error sets bit 7 with no cause bit.
// [RULE8] Info bit 4 flags an illegal command.
// [RULE9] Receive info bit 3 flags fewer data words than counted.
// [RULE10] Receive info bit 2 flags unexpected or excess words.
// [RULE11] Receive info bit 1 flags a data word parity error.
// [RULE12] Receive info bit 0 flags a data word Manchester error.
// [RULE13] Host lays out transmit data with two reserved words ahead.
// [RULE14] Transmit pointer names the reserved words; data fetched from pointer plus two.
// [RULE15] Transmit info bit 2 flags received data; bits 8,3,1,0 zero.
// [RULE16] Receive mode code with data stores exactly one data word.
// [RULE17] Synchronize-with-data loads the time-tag counter and stores the word.
// [RULE18] Internally generated mode code data is written into the structure.
// [RULE19] Legacy mode: mode codes carry no data, direction bit ignored.
// [RULE20] Mode code info bits 15..11 carry the mode code field.
// [RULE21] Host points the descriptor at host-supplied transmit mode data.
// [RULE22] Time-tag word is the sixteen-bit counter at command validity.
// [RULE23] Index mode writes the advanced data pointer back into the descriptor.
// [RULE24] Unused information word bits are written as zero.
module rt_message_writer
    import rt_writer_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // Wishbone slave
    input  wire logic [WB_ADR_W-1:0] adr_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    input  wire logic                we_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    output logic                     ack_o,
    // Message events from the terminal engine
    input  wire logic                cmdValid,
    input  wire logic [15:0]         cmdWord,
    input  wire logic                channelA,
    input  wire logic                rtToRt,
    input  wire logic                illegalCmd,
    input  wire logic [15:0]         dataPointer,
    input  wire logic [15:0]         descriptorAddr,
    input  wire logic                indexWriteback,
    input  wire logic [15:0]         internalData,
    input  wire logic                wordValid,
    input  wire logic [15:0]         wordData,
    input  wire logic                wordParityErr,
    input  wire logic                wordManchErr,
    input  wire logic                linkError,
    input  wire logic                msgEnd,
    input  wire logic                timeTick,
    output logic                     wordReady,
    output logic [15:0]              txFetchAddr,
    output logic                     msgDone,
    // Host memory write port
    output logic                     memReq,
    output logic [15:0]              memAddr,
    output logic [15:0]              memData,
    input  wire logic                memAck
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic isModeCmd(input logic [15:0] cw);
        return (cw[CMD_SA_MSB:CMD_SA_LSB] == SA_MODE_LO) ||
               (cw[CMD_SA_MSB:CMD_SA_LSB] == SA_MODE_HI);
    endfunction : isModeCmd

    function automatic logic [CNT_W-1:0] expectedWords(input logic [15:0] cw,
                                                       input logic        legacy);
        logic [4:0] cnt;
        cnt = cw[CMD_CNT_MSB:CMD_CNT_LSB];
        if (isModeCmd(cw)) begin
            // [RULE16] one word for receive mode codes with data
            // [RULE19] none at all in legacy mode
            expectedWords = (!legacy && !cw[CMD_TR_BIT] && cnt[MC_DATA_BIT]) ?
                            CNT_W'(1) : CNT_W'(0);
        end else if (cw[CMD_TR_BIT]) begin
            expectedWords = CNT_W'(0);
        end else begin
            expectedWords = (cnt == 5'h00) ? CNT_W'(MAX_WORDS) : CNT_W'(cnt);
        end
    endfunction : expectedWords

    ////////////////////////////////////////////////////////////////////////////
    // Registers and message context

    state_t           state;
    logic [31:0]      control;
    logic [15:0]      lastInfo;
    logic [15:0]      msgCount;
    logic [15:0]      timeTag;
    logic [15:0]      tagLatch;
    logic [15:0]      cmdLatch;
    logic [15:0]      basePtr;
    logic [15:0]      descLatch;
    logic             chanLatch;
    logic             rtrtLatch;
    logic             illLatch;
    logic             indexLatch;
    logic             txType;
    logic             genData;
    logic [CNT_W-1:0] expected;
    logic [CNT_W-1:0] wordCount;
    logic             excessErr;
    logic             parityErr;
    logic             manchErr;
    logic             extErr;
    logic             legacy;
    logic             storeWord;
    logic             syncLoad;
    logic             shortErr;
    logic [15:0]      infoWord;

    assign legacy = control[CTRL_LEGACY];

    // Once any fault is seen, later data words are not stored
    // [RULE3] data after an error is not written
    // Illegal commands count as message errors, so their data is never stored
    assign storeWord = wordValid && !txType && (wordCount < expected) && !wordParityErr &&
                       !wordManchErr && !excessErr && !parityErr && !manchErr && !extErr &&
                       !illLatch;

    // [RULE17] time-tag load from synchronize-with-data
    assign syncLoad = (state == S_COLLECT) && storeWord && isModeCmd(cmdLatch) &&
                      (cmdLatch[CMD_CNT_MSB:CMD_CNT_LSB] == MC_SYNC_DATA);

    // [RULE9] short message
    assign shortErr = !txType && (wordCount < expected);

    always_comb begin
        infoWord = 16'h0000;
        // [RULE4] count or mode code field
        // [RULE20] same position for mode codes
        infoWord[INFO_CNT_MSB:INFO_CNT_LSB] = cmdLatch[CMD_CNT_MSB:CMD_CNT_LSB];
        // [RULE5] channel flag
        infoWord[INFO_CHAN] = chanLatch;
        // [RULE8] illegal command flag
        infoWord[INFO_ILLEGAL] = illLatch;
        // [RULE10] excess words
        // [RULE15] transmit overrun
        infoWord[INFO_EXCESS] = excessErr;
        // [RULE24] transmit-type words leave 8, 3, 1 and 0 at zero
        if (!txType) begin
            // [RULE6] terminal-to-terminal flag
            infoWord[INFO_TERMINAL_TO_TERMINAL_FLAG] = rtrtLatch;
            infoWord[INFO_SHORT] = shortErr;
            // [RULE11] parity fault
            infoWord[INFO_PARITY] = parityErr;
            // [RULE12] Manchester fault
            infoWord[INFO_MANCH] = manchErr;
        end
        // [RULE7] summary error bit
        infoWord[INFO_MSGERR] = extErr || (|infoWord[INFO_ILLEGAL:INFO_MANCH]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Message context capture and error tracking

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmdLatch <= 16'h0000;
            basePtr <= 16'h0000;
            descLatch <= 16'h0000;
            txFetchAddr <= 16'h0000;
            tagLatch <= 16'h0000;
            chanLatch <= 1'b0;
            rtrtLatch <= 1'b0;
            illLatch <= 1'b0;
            indexLatch <= 1'b0;
            txType <= 1'b0;
            genData <= 1'b0;
            expected <= '0;
            wordCount <= '0;
            excessErr <= 1'b0;
            parityErr <= 1'b0;
            manchErr <= 1'b0;
            extErr <= 1'b0;
        end else if (state == S_IDLE && cmdValid && control[CTRL_ENABLE]) begin
            cmdLatch <= cmdWord;
            basePtr <= dataPointer;
            descLatch <= descriptorAddr;
            // [RULE14] transmit data starts past the two reserved words
            txFetchAddr <= dataPointer + DATA_OFFSET;
            // [RULE22] time-tag sampled at command validity
            tagLatch <= timeTag;
            chanLatch <= channelA;
            rtrtLatch <= rtToRt;
            illLatch <= illegalCmd;
            indexLatch <= indexWriteback;
            // [RULE19] direction ignored for legacy mode codes
            txType <= cmdWord[CMD_TR_BIT] && !(legacy && isModeCmd(cmdWord));
            // [RULE18] internally generated transmit mode data
            genData <= !legacy && isModeCmd(cmdWord) && cmdWord[CMD_TR_BIT] &&
                       ((cmdWord[CMD_CNT_MSB:CMD_CNT_LSB] == MC_BIT_WORD) ||
                        (cmdWord[CMD_CNT_MSB:CMD_CNT_LSB] == MC_LAST_CMD));
            expected <= expectedWords(cmdWord, legacy);
            wordCount <= '0;
            excessErr <= 1'b0;
            parityErr <= 1'b0;
            manchErr <= 1'b0;
            extErr <= 1'b0;
        end else if (state == S_COLLECT || state == S_DATA) begin
            if (wordValid) begin
                if (wordCount != '1) begin
                    wordCount <= wordCount + CNT_W'(1);
                end
                // [RULE10] word beyond the count or none expected
                if (txType || wordCount >= expected) begin
                    excessErr <= 1'b1;
                end
                if (wordParityErr) begin
                    parityErr <= 1'b1;
                end
                if (wordManchErr) begin
                    manchErr <= 1'b1;
                end
            end
            if (linkError) begin
                extErr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time-tag counter

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timeTag <= 16'h0000;
        end else if (syncLoad) begin
            timeTag <= wordData;
        end else if (timeTick) begin
            timeTag <= timeTag + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Structure writer: data words as they arrive, then info, tag and tail

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= S_IDLE;
            memReq <= 1'b0;
            memAddr <= 16'h0000;
            memData <= 16'h0000;
            msgDone <= 1'b0;
            wordReady <= 1'b0;
            lastInfo <= 16'h0000;
            msgCount <= 16'h0000;
        end else begin
            msgDone <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (cmdValid && control[CTRL_ENABLE]) begin
                        state <= S_COLLECT;
                        wordReady <= 1'b1;
                    end
                end
                S_COLLECT: begin
                    if (msgEnd) begin
                        // [RULE1] info word leads the structure
                        // [RULE3] written even after an error
                        wordReady <= 1'b0;
                        state <= S_INFO;
                        memReq <= 1'b1;
                        memAddr <= basePtr + INFO_OFFSET;
                        memData <= infoWord;
                        lastInfo <= infoWord;
                    end else if (storeWord) begin
                        // [RULE2] data lands at pointer plus two onward
                        wordReady <= 1'b0;
                        state <= S_DATA;
                        memReq <= 1'b1;
                        memAddr <= basePtr + DATA_OFFSET + 16'(wordCount);
                        memData <= wordData;
                    end
                end
                S_DATA: begin
                    if (memAck) begin
                        memReq <= 1'b0;
                        wordReady <= 1'b1;
                        state <= S_COLLECT;
                    end
                end
                S_INFO: begin
                    if (memAck) begin
                        // [RULE1] time-tag follows the info word
                        state <= S_TAG;
                        memAddr <= basePtr + TAG_OFFSET;
                        memData <= tagLatch;
                    end
                end
                S_TAG: begin
                    if (memAck) begin
                        if (genData) begin
                            // [RULE18] generated word stored after the tag
                            state <= S_GEN;
                            memAddr <= basePtr + DATA_OFFSET;
                            memData <= internalData;
                        end else if (indexLatch) begin
                            // [RULE23] advance pointer past this structure
                            state <= S_INDEX;
                            memAddr <= descLatch + DPTR_OFFSET;
                            memData <= basePtr + DATA_OFFSET + 16'(expected);
                        end else begin
                            memReq <= 1'b0;
                            state <= S_DONE;
                        end
                    end
                end
                S_GEN: begin
                    if (memAck) begin
                        if (indexLatch) begin
                            state <= S_INDEX;
                            memAddr <= descLatch + DPTR_OFFSET;
                            memData <= basePtr + DATA_OFFSET + 16'(expected);
                        end else begin
                            memReq <= 1'b0;
                            state <= S_DONE;
                        end
                    end
                end
                S_INDEX: begin
                    if (memAck) begin
                        memReq <= 1'b0;
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    msgDone <= 1'b1;
                    msgCount <= msgCount + 16'h0001;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads return zero

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            control <= CONTROL_RST;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (cyc_i && stb_i && !ack_o) begin
                if (we_i && adr_i == REG_CONTROL && sel_i[0]) begin
                    control <= {30'h0000_0000, dat_i[CTRL_ENABLE:CTRL_LEGACY]};
                end
                unique case (adr_i)
                    REG_CONTROL:  dat_o <= control;
                    REG_STATUS:   dat_o <= {15'h0000, state != S_IDLE, lastInfo};
                    REG_MSGCOUNT: dat_o <= {16'h0000, msgCount};
                    REG_TIMETAG:  dat_o <= {16'h0000, timeTag};
                    default:      dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_infoDone;
        state == S_INFO && memAck;
    endsequence
    sequence s_tagOut;
        state == S_TAG && memReq && memAddr == basePtr + TAG_OFFSET;
    endsequence

    property p_infoThenTag;
        s_infoDone |=> s_tagOut;
    endproperty
    a_infoThenTag: assert property (p_infoThenTag) else $error("tag not after info"); // [RULE1]

    property p_dataAddr;
        state == S_COLLECT && storeWord && !msgEnd |=>
            memReq && memAddr == $past(basePtr) + DATA_OFFSET + 16'($past(wordCount));
    endproperty
    a_dataAddr: assert property (p_dataAddr) else $error("data address wrong"); // [RULE2]

    property p_errStillInfo;
        state == S_COLLECT && msgEnd |=> state == S_INFO && memReq && memAddr == basePtr;
    endproperty
    a_errStillInfo: assert property (p_errStillInfo) else $error("info not written"); // [RULE3]

    property p_countField;
        state == S_INFO && memReq |-> memData[INFO_CNT_MSB:INFO_CNT_LSB] ==
            cmdLatch[CMD_CNT_MSB:CMD_CNT_LSB];
    endproperty
    a_countField: assert property (p_countField) else $error("count field wrong"); // [RULE4]

    property p_channel;
        state == S_INFO && memReq |-> memData[INFO_CHAN] == chanLatch;
    endproperty
    a_channel: assert property (p_channel) else $error("channel bit wrong"); // [RULE5]

    property p_summary;
        state == S_INFO && memReq && (|memData[INFO_ILLEGAL:INFO_MANCH]) |->
            memData[INFO_MSGERR];
    endproperty
    a_summary: assert property (p_summary) else $error("error summary missing"); // [RULE7]

    property p_txUnused;
        state == S_INFO && memReq && txType |-> !memData[INFO_TERMINAL_TO_TERMINAL_FLAG] &&
            !memData[INFO_SHORT] && !memData[INFO_PARITY] && !memData[INFO_MANCH];
    endproperty
    a_txUnused: assert property (p_txUnused) else $error("transmit unused bit set"); // [RULE15]

    property p_syncLoad;
        syncLoad |=> timeTag == $past(wordData);
    endproperty
    a_syncLoad: assert property (p_syncLoad) else $error("time-tag not loaded"); // [RULE17]

    property p_legacyNoData;
        legacy && state == S_COLLECT && isModeCmd(cmdLatch) |-> !storeWord && !genData;
    endproperty
    a_legacyNoData: assert property (p_legacyNoData) else $error("legacy data stored"); // [RULE19]

    property p_donePulse;
        msgDone |=> !msgDone && state == S_IDLE;
    endproperty
    a_donePulse: assert property (p_donePulse) else $error("done not a pulse"); // [RULE1]

endmodule : rt_message_writer

// >>> common/rt_writer_pkg.sv
// Constants, field layout and state encoding for the message structure writer
package rt_writer_pkg;

    // Command word layout (bus bit times 4..19 map onto bits 15..0)
    localparam int CMD_TR_BIT     = 10;
    localparam int CMD_SA_MSB     = 9;
    localparam int CMD_SA_LSB     = 5;
    localparam int CMD_CNT_MSB    = 4;
    localparam int CMD_CNT_LSB    = 0;

    // Information word layout
    localparam int INFO_CNT_MSB   = 15;
    localparam int INFO_CNT_LSB   = 11;
    localparam int INFO_CHAN      = 9;
    localparam int INFO_TERMINAL_TO_TERMINAL_FLAG      = 8;
    localparam int INFO_MSGERR    = 7;
    localparam int INFO_ILLEGAL   = 4;
    localparam int INFO_SHORT     = 3;
    localparam int INFO_EXCESS    = 2;
    localparam int INFO_PARITY    = 1;
    localparam int INFO_MANCH     = 0;

    // Structure offsets from the selected data pointer
    localparam logic [15:0] INFO_OFFSET = 16'h0000;
    localparam logic [15:0] TAG_OFFSET  = 16'h0001;
    localparam logic [15:0] DATA_OFFSET = 16'h0002;
    // Data pointer A is the second word of a descriptor block
    localparam logic [15:0] DPTR_OFFSET = 16'h0001;

    // Subaddress values that select a mode code
    localparam logic [4:0] SA_MODE_LO   = 5'h00;
    localparam logic [4:0] SA_MODE_HI   = 5'h1f;
    // Mode codes handled specially
    localparam logic [4:0] MC_SYNC_DATA = 5'h11;
    localparam logic [4:0] MC_LAST_CMD  = 5'h12;
    localparam logic [4:0] MC_BIT_WORD  = 5'h13;
    localparam int         MC_DATA_BIT  = 4;
    localparam logic [5:0] MAX_WORDS    = 6'h20;

    // Register map (byte addresses)
    localparam int          WB_ADR_W     = 8;
    localparam logic [7:0]  REG_CONTROL  = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_MSGCOUNT = 8'h08;
    localparam logic [7:0]  REG_TIMETAG  = 8'h0c;
    localparam int          CTRL_LEGACY  = 0;
    localparam int          CTRL_ENABLE  = 1;
    localparam int          STAT_BUSY    = 16;
    localparam logic [31:0] CONTROL_RST  = 32'h0000_0002;

    typedef enum {S_IDLE, S_COLLECT, S_DATA, S_INFO, S_TAG, S_GEN, S_INDEX, S_DONE} state_t;

endpackage : rt_writer_pkg

// >>> test/rt_memory_model.sv
// Host memory model answering structure writes
module rt_memory_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       memReq,
    input  wire logic [3:0] memDelay,
    output logic            memAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCount;

    // host keeps layout
    // A request must stand memDelay plus one cycles before memAck, so slow memory is exercised
    always_ff @(posedge ref_clk) begin
        if (rst || !memReq || memAck) begin
            waitCount <= '0;
            memAck <= '0;
        end else if (waitCount >= memDelay) begin
            memAck <= '1;
        end else begin
            waitCount <= waitCount + 4'h1;
        end
    end
endmodule : rt_memory_model

// >>> test/test_rt_message_data_structure_writer.sv
// Self-checking bench for the message structure writer
module test_rt_message_data_structure_writer
    import rt_writer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = '0, rst = '1, we_i = '0, cyc_i = '0, stb_i = '0, ack_o;
    logic        cmdValid = '0, channelA = '0, rtToRt = '0, illegalCmd = '0;
    logic        indexWriteback = '0, wordValid = '0, wordParityErr = '0;
    logic        wordManchErr = '0, linkError = '0, msgEnd = '0, timeTick = '0;
    logic        wordReady, msgDone, memReq, memAck;
    logic [7:0]  adr_i = '0;
    logic [3:0]  sel_i = '0, memDelay = '0;
    logic [31:0] dat_i = '0, dat_o, rd, seed = 32'he0c49d75;
    logic [15:0] cmdWord = '0, dataPointer = '0, descriptorAddr = '0, internalData = '0;
    logic [15:0] wordData = '0, txFetchAddr, memAddr, memData, ptr, tagNow, lastInfo, cmd;
    logic [15:0] dw[2];
    logic [31:0] expQ[$];
    int          fail_count = 0, checks_done = 0;

    always #2.5 ref_clk = ~ref_clk;
    rt_message_writer dut (.*);
    rt_memory_model mem (.*);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction : rnd
    task automatic fail(input string m);
        fail_count++;
        $display("Error %0t %s", $time, m);
    endtask : fail
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) fail(m);
    endtask : check
    task automatic test_done();
        if (expQ.size() != 0) fail("missing write");
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    // Bounded wait for a level sampled at a rising edge
    task automatic waitFor(ref logic s);
        int n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (s !== 1'b1 && n < 99);
        if (n >= 99) begin
            fail("timeout");
            test_done();
        end
    endtask : waitFor
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        cyc_i <= '1;
        stb_i <= '1;
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hf;
        waitFor(ack_o);
        rd = dat_o;
        cyc_i <= '0;
        stb_i <= '0;
        @(posedge ref_clk);
    endtask : wb
    task automatic fresh(input logic [15:0] c);
        cmd = c;
        ptr = rnd();
        dw[0] = rnd();
        dw[1] = rnd();
        internalData <= dw[1];
        memDelay <= {1'b0, seed[2:0]};
    endtask : fresh
    task automatic ex(input logic [15:0] a, input logic [15:0] d);
        expQ.push_back({a, d});
    endtask : ex
    // f: channel A, terminal-to-terminal, illegal, link error, index
    task automatic head(input logic [4:0] f, input logic [3:0] low);
        lastInfo = {cmd[4:0], 1'b0, f[4], f[3] & ~cmd[10], |{f[2:1], low}, 2'b0, f[2], low};
        ex(ptr, lastInfo);
        ex(ptr + 16'h1, tagNow);
    endtask : head
    task automatic send(input logic [4:0] f, input int n, input logic [1:0] bad);
        cmdWord <= cmd;
        dataPointer <= ptr;
        {channelA, rtToRt, illegalCmd, indexWriteback} <= {f[4:2], f[0]};
        cmdValid <= '1;
        @(posedge ref_clk);
        cmdValid <= '0;
        linkError <= f[1];
        timeTick <= '1;
        @(posedge ref_clk);
        linkError <= '0;
        timeTick <= '0;
        for (int i = 0; i < n; i++) begin
            waitFor(wordReady);
            wordValid <= '1;
            wordData <= dw[i];
            {wordParityErr, wordManchErr} <= (i == 0) ? bad : 2'h0;
            @(posedge ref_clk);
            wordValid <= '0;
        end
        waitFor(wordReady);
        msgEnd <= '1;
        @(posedge ref_clk);
        msgEnd <= '0;
        waitFor(msgDone);
        tagNow = tagNow + 16'h0001;
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    // Each memory write must match the oldest expected write
    always @(posedge ref_clk) begin
        if (memReq === 1'b1 && memAck === 1'b1) begin
            checks_done++;
            if (expQ.size() == 0) fail("unexpected write");
            else if (expQ.pop_front() !== {memAddr, memData}) fail("memory write");
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= '0;
        descriptorAddr <= rnd();
        timeTick <= '1;
        repeat (3) @(posedge ref_clk);
        timeTick <= '0;
        tagNow = 16'h3;
        wb(REG_CONTROL, '0, '0);
        check(rd, CONTROL_RST, "control reset");
        wb(8'h10, '0, '0);
        check(rd, '0, "unmapped read");
        fresh(16'h0822);
        ex(ptr + 16'h2, dw[0]);
        ex(ptr + 16'h3, dw[1]);
        head(5'b10001, 4'h0);
        ex(descriptorAddr + 16'h1, ptr + 16'h4);
        send(5'b10001, 2, 2'h0);
        wb(REG_STATUS, '0, '0);
        check(rd, {16'h0, lastInfo}, "status");
        fresh(16'h0823);
        ex(ptr + 16'h2, dw[0]);
        head(5'b01000, 4'h8);
        send(5'b01000, 1, 2'h0);
        fresh(16'h0821);
        ex(ptr + 16'h2, dw[0]);
        head(5'b00000, 4'h4);
        send(5'b00000, 2, 2'h0);
        for (int b = 1; b < 3; b++) begin
            fresh(16'h0821);
            head(5'b00000, 4'(b));
            send(5'b00000, 1, 2'(b));
            fresh(16'h0821);
            head(5'(b * 2), 4'h0);
            send(5'(b * 2), 1, 2'h0);
        end
        fresh(16'h0c42);
        head(5'b01000, 4'h4);
        send(5'b01000, 1, 2'h0);
        check(txFetchAddr, ptr + 16'h2, "fetch address");
        fresh(16'h0811);
        ex(ptr + 16'h2, dw[0]);
        head(5'b00000, 4'h0);
        send(5'b00000, 1, 2'h0);
        tagNow = dw[0];
        wb(REG_TIMETAG, '0, '0);
        check(rd, {16'h0, tagNow}, "time tag");
        for (int m = 0; m < 2; m++) begin
            fresh(16'h0ff2 + 16'(m));
            head(5'b00000, 4'h0);
            ex(ptr + 16'h2, dw[1]);
            send(5'b00000, 0, 2'h0);
        end
        // Vector word data is host-supplied: only info and tag are written
        fresh(16'h0ff0);
        head(5'b00000, 4'h0);
        send(5'b00000, 0, 2'h0);
        wb(REG_CONTROL, '1, 32'h3);
        // A data word under a legacy mode code is an overrun and is not stored
        for (int m = 0; m < 2; m++) begin
            fresh(m ? 16'h0ff3 : 16'h0811);
            head(5'b00000, 4'h4);
            send(5'b00000, 1, 2'h0);
        end
        wb(REG_MSGCOUNT, '0, '0);
        check(rd, 32'h0000_000e, "message count");
        test_done();
    end
endmodule : test_rt_message_data_structure_writer
